/* File: skx_exec.sv */
// Execution unit for nibble exchange, zero skips, table reads and XOR forms.
// Assumes a core that offers one operation at a time with operands attached,
// an asynchronous program memory read, and a core that writes mem_wr_data_o
// to the addressed byte when mem_wr_o pulses.
`timescale 1ns/1ps
`default_nettype none
module skx_exec
    import skx_pkg::*;
(
    input  wire logic              ref_clk_i,      // Core clock, 10 MHz
    input  wire logic              rst_i,          // Async reset, high
    input  wire logic              op_valid_i,     // Operation offered
    input  wire skx_op_t           op_code_i,      // Operation code
    input  wire logic [DATA_W-1:0] mem_rd_data_i,  // Addressed memory byte
    input  wire logic [BSEL_W-1:0] bit_sel_i,      // Bit under test
    input  wire logic [DATA_W-1:0] imm_i,          // Immediate byte
    input  wire logic [PTR_W-1:0]  table_pointer_i,// Table pointer value
    input  wire logic [PAGE_W-1:0] cur_page_i,     // Current program page
    input  wire logic [ROM_W-1:0]  rom_data_i,     // Program word read
    output logic                   ready_o,        // Operation can be taken
    output logic                   rom_rd_o,       // Program memory read
    output logic [ROM_AW-1:0]      rom_addr_o,     // Program read address
    output logic                   mem_wr_o,       // Memory write pulse
    output logic [DATA_W-1:0]      mem_wr_data_o,  // Memory write byte
    output logic [DATA_W-1:0]      acc_o,          // Accumulator
    output logic                   zero_o,         // Zero flag
    output logic [THI_W-1:0]       table_high_byte_reg_o, // Table-high reg
    output logic                   skip_o          // Discard prefetch pulse
);
    skx_alu_if          alu_io ();     // Datapath bundle
    skx_state_t         state_q;       // Sequencer state
    logic               accept;        // Operation taken this cycle
    logic [DATA_W-1:0]  acc_q;         // Accumulator register
    logic               zero_q;        // Zero flag register
    logic [THI_W-1:0]   thi_q;         // Table-high register
    logic [ROM_AW-1:0]  radr_q;        // Latched program address
    logic               mem_wr_q;      // Memory write strobe
    logic [DATA_W-1:0]  mem_wd_q;      // Memory write byte
    logic               skip_q;        // Prefetch discard pulse

    // Last-page select, used by the table read address
    function automatic logic [PAGE_W-1:0] page_of(input skx_op_t op,
                                                  input logic [PAGE_W-1:0] cur);
        page_of = (op == OP_TRD_LAST) ? LAST_PAGE : cur;
    endfunction : page_of

    // Operands to the datapath
    assign alu_io.op   = op_code_i;
    assign alu_io.mem  = mem_rd_data_i;
    assign alu_io.acc  = acc_q;
    assign alu_io.imm  = imm_i;
    assign alu_io.bsel = bit_sel_i;

    skx_alu u_alu (
        .io (alu_io)
    );

    // Handshake
    assign ready_o = (state_q == ST_RUN);
    assign accept  = op_valid_i && ready_o;
    assign rom_rd_o = (state_q == ST_TABLE);

    // Outputs from flops
    assign rom_addr_o            = radr_q;
    assign mem_wr_o              = mem_wr_q;
    assign mem_wr_data_o         = mem_wd_q;
    assign acc_o                 = acc_q;
    assign zero_o                = zero_q;
    assign table_high_byte_reg_o = thi_q;
    assign skip_o                = skip_q;

    // Sequencer
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_RUN;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (accept && alu_io.skip) begin
                        state_q <= ST_DUMMY;
                    end else if (accept && alu_io.table_rd) begin
                        state_q <= ST_TABLE;
                    end
                end
                ST_DUMMY: state_q <= ST_RUN;   // Dummy cycle done
                ST_TABLE: state_q <= ST_RUN;   // Word captured
                default:  state_q <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            skip_q <= 1'b0;
        end else begin
            skip_q <= accept && alu_io.skip;
        end
    end

    // Accumulator
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_q <= ACC_RST;
        end else if (accept && alu_io.wr_acc) begin
            acc_q <= alu_io.result;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            zero_q <= ZERO_RST;
        end else if (accept && alu_io.upd_z) begin
            zero_q <= (alu_io.result == '0);
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            radr_q <= RADR_RST;
        end else if (accept && alu_io.table_rd) begin
            radr_q <= {page_of(op_code_i, cur_page_i), table_pointer_i};
        end
    end

    // Table-high capture
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            thi_q <= THI_RST;
        end else if (state_q == ST_TABLE) begin
            thi_q <= rom_data_i[ROM_W-1:DATA_W];
        end
    end

    // Memory write port
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_wr_q <= 1'b0;
            mem_wd_q <= '0;
        end else if (state_q == ST_TABLE) begin
            mem_wr_q <= 1'b1;
            mem_wd_q <= rom_data_i[DATA_W-1:0];
        end else begin
            mem_wr_q <= accept && alu_io.wr_mem;
            mem_wd_q <= alu_io.result;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_take(skx_op_t op);
        accept && op_code_i == op;
    endsequence

    nibble_swap_a: assert property (
        s_take(OP_NIBX_ACC) |=> acc_o == {$past(mem_rd_data_i[3:0]),
                                          $past(mem_rd_data_i[7:4])})
        else $error("nibble exchange result wrong");
    nibble_mem_keep_a: assert property (
        s_take(OP_NIBX_ACC) |=> !mem_wr_o && $stable(zero_o))
        else $error("nibble exchange touched memory or flag");
    byte_zero_skip_a: assert property (
        s_take(OP_SKZ) |=> skip_o == ($past(mem_rd_data_i) == 8'h00))
        else $error("zero byte skip wrong");
    copy_skip_a: assert property (
        s_take(OP_CPY_SKZ) |=> acc_o == $past(mem_rd_data_i)
                               && skip_o == (acc_o == 8'h00))
        else $error("copy and skip wrong");
    bit_clear_skip_a: assert property (
        s_take(OP_SKBC) |=> skip_o == !$past(mem_rd_data_i[bit_sel_i]))
        else $error("bit clear skip wrong");
    skip_dummy_a: assert property (
        accept && alu_io.skip |=> !ready_o && skip_o ##1 ready_o && !skip_o)
        else $error("skip dummy cycle wrong");
    table_cur_a: assert property (
        s_take(OP_TRD_CUR) |=> rom_rd_o && !ready_o
            && rom_addr_o == {$past(cur_page_i), $past(table_pointer_i)}
            ##1 mem_wr_o && ready_o
            && mem_wr_data_o == $past(rom_data_i[7:0])
            && table_high_byte_reg_o == $past(rom_data_i[13:8]))
        else $error("current page table read wrong");
    table_last_a: assert property (
        s_take(OP_TRD_LAST) |=> rom_rd_o
            && rom_addr_o == {LAST_PAGE, $past(table_pointer_i)}
            ##1 mem_wr_o && mem_wr_data_o == $past(rom_data_i[7:0]))
        else $error("last page table read wrong");
    xor_acc_a: assert property (
        s_take(OP_XOR_ACC) |=> acc_o == ($past(acc_o) ^ $past(mem_rd_data_i))
                               && !mem_wr_o)
        else $error("xor into accumulator wrong");
    xor_mem_a: assert property (
        s_take(OP_XOR_MEM) |=> mem_wr_o && $stable(acc_o)
            && mem_wr_data_o == ($past(acc_o) ^ $past(mem_rd_data_i)))
        else $error("xor into memory wrong");
    xor_imm_a: assert property (
        s_take(OP_XOR_IMM) |=> acc_o == ($past(acc_o) ^ $past(imm_i)))
        else $error("xor immediate wrong");
    zero_flag_a: assert property (
        accept && alu_io.upd_z |=> zero_o == ($past(alu_io.result) == 8'h00))
        else $error("zero flag wrong");
endmodule : skx_exec
`default_nettype wire

/* File: skx_pkg.sv */
// Shared constants and types for the skip, table-read and XOR execution unit.
// Assumes one core clock and one active-high asynchronous core reset.
`default_nettype none
package skx_pkg;
    // Data path and program memory widths
    localparam int unsigned DATA_W  = 8;                  // Data memory byte
    localparam int unsigned ROM_W   = 14;                 // Program word
    localparam int unsigned ROM_AW  = 11;                 // Program address
    localparam int unsigned PTR_W   = 8;                  // Table pointer
    localparam int unsigned PAGE_W  = ROM_AW - PTR_W;     // Page number
    localparam int unsigned THI_W   = ROM_W - DATA_W;     // Table-high width
    localparam int unsigned BSEL_W  = 3;                  // Bit selector
    localparam int unsigned NIB_W   = 4;                  // Nibble width
    // Page fixed for the last-page table read
    localparam logic [PAGE_W-1:0] LAST_PAGE = 3'h7;
    // Values after reset
    localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
    localparam logic              ZERO_RST = 1'b0;
    localparam logic [THI_W-1:0]  THI_RST  = 6'h00;
    localparam logic [ROM_AW-1:0] RADR_RST = 11'h000;
    // Cycle counts of the multi-cycle forms
    localparam int unsigned SKIP_CYCLES  = 2;             // Skip taken
    localparam int unsigned TABLE_CYCLES = 2;             // Table read

    // Operations handled by the unit
    typedef enum logic [3:0] {
        OP_NOP,        // No operation
        OP_NIBX_ACC,   // nibble_exchange_to_accumulator
        OP_SKZ,        // skip_when_byte_zero
        OP_CPY_SKZ,    // copy_then_skip_when_zero
        OP_SKBC,       // Skip when selected bit clear
        OP_TRD_CUR,    // table_read_current_page
        OP_TRD_LAST,   // table_read_last_page
        OP_XOR_ACC,    // Accumulator xor memory into accumulator
        OP_XOR_MEM,    // exclusive_or_into_memory
        OP_XOR_IMM     // Accumulator xor immediate
    } skx_op_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_RUN,        // Accepting operations
        ST_DUMMY,      // Dummy cycle after a taken skip
        ST_TABLE       // Program memory word being read
    } skx_state_t;
endpackage : skx_pkg
`default_nettype wire

/* File: skx_alu_if.sv */
// Operand and result bundle between the sequencer and the datapath.
// Assumes both ends share the core clock; contents are combinational.
`timescale 1ns/1ps
`default_nettype none
interface skx_alu_if;
    import skx_pkg::*;
    skx_op_t           op;        // Operation
    logic [DATA_W-1:0] mem;       // Addressed memory byte
    logic [DATA_W-1:0] acc;       // Accumulator value
    logic [DATA_W-1:0] imm;       // Immediate byte
    logic [BSEL_W-1:0] bsel;      // Selected bit
    logic [DATA_W-1:0] result;    // Computed byte
    logic              skip;      // Skip is taken
    logic              wr_acc;    // Result goes to accumulator
    logic              wr_mem;    // Result goes to memory
    logic              upd_z;     // Zero flag follows result
    logic              table_rd;  // Table read operation
    modport core (output op, mem, acc, imm, bsel,
                  input  result, skip, wr_acc, wr_mem, upd_z, table_rd);
    modport alu  (input  op, mem, acc, imm, bsel,
                  output result, skip, wr_acc, wr_mem, upd_z, table_rd);
endinterface : skx_alu_if
`default_nettype wire

/* File: skx_alu.sv */
// Combinational datapath: result byte, skip decision and write targets.
// Assumes operands are stable for the cycle in which they are offered.
`timescale 1ns/1ps
`default_nettype none
module skx_alu
    import skx_pkg::*;
(
    skx_alu_if.alu io             // Operands in, results out
);
    logic [DATA_W-1:0] swapped;   // Nibble-exchanged memory byte

    for (genvar i = 0; i < DATA_W; i++) begin : g_swap
        assign swapped[i] = io.mem[(i + NIB_W) % DATA_W];
    end

    // Decode result, skip and destinations
    always_comb begin
        io.result   = '0;
        io.skip     = 1'b0;
        io.wr_acc   = 1'b0;
        io.wr_mem   = 1'b0;
        io.upd_z    = 1'b0;
        io.table_rd = 1'b0;
        case (io.op)
            OP_NIBX_ACC: begin
                io.result = swapped;
                io.wr_acc = 1'b1;
            end
            OP_SKZ: begin
                io.skip = (io.mem == '0);
            end
            OP_CPY_SKZ: begin
                io.result = io.mem;
                io.wr_acc = 1'b1;
                io.skip   = (io.mem == '0);
            end
            OP_SKBC: begin
                io.skip = ~io.mem[io.bsel];
            end
            OP_TRD_CUR, OP_TRD_LAST: begin
                // Table forms finish in the sequencer
                io.table_rd = 1'b1;
            end
            OP_XOR_ACC: begin
                io.result = io.acc ^ io.mem;
                io.wr_acc = 1'b1;
                io.upd_z  = 1'b1;
            end
            OP_XOR_MEM: begin
                io.result = io.acc ^ io.mem;
                io.wr_mem = 1'b1;
                io.upd_z  = 1'b1;
            end
            OP_XOR_IMM: begin
                io.result = io.acc ^ io.imm;
                io.wr_acc = 1'b1;
                io.upd_z  = 1'b1;
            end
            default: begin
                // No effect
                io.result = '0;
            end
        endcase
    end
endmodule : skx_alu
`default_nettype wire

/* File: tb_skip_table_xor_instr_exec.sv */
// Self-checking bench for the skip, table-read and XOR execution unit.
// Assumes skx_pkg and the unit's files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_skip_table_xor_instr_exec;
    import skx_pkg::*;
    logic              clk = 1'b0;   // Core clock
    logic              rst;          // Core reset
    logic              valid;        // Operation offered
    skx_op_t           op;           // Operation code
    logic [7:0]        mem_rd;       // Addressed byte
    logic [2:0]        bsel;         // Bit under test
    logic [7:0]        imm;          // Immediate byte
    logic [7:0]        tptr;         // Table pointer
    logic [2:0]        page;         // Current page
    logic [13:0]       rom;          // Program word
    logic              ready;        // Unit can accept
    logic              rom_rd;       // Program read strobe
    logic [10:0]       rom_addr;     // Program address
    logic              mem_wr;       // Memory write pulse
    logic [7:0]        wr_data;      // Memory write byte
    logic [7:0]        acc;          // Accumulator
    logic              zero;         // Zero flag
    logic [5:0]        tbh;          // Table-high register
    logic              skip;         // Discard pulse
    logic [7:0]        m_acc;        // Expected accumulator
    logic              m_z;          // Expected zero flag
    int                miscompares = 0;
    int                check_count = 0;

    // Free-running 100 ns core clock
    always #50 clk = ~clk;

    skx_exec i_dut (
        .ref_clk_i(clk), .rst_i(rst), .op_valid_i(valid), .op_code_i(op),
        .mem_rd_data_i(mem_rd), .bit_sel_i(bsel), .imm_i(imm),
        .table_pointer_i(tptr), .cur_page_i(page), .rom_data_i(rom),
        .ready_o(ready), .rom_rd_o(rom_rd), .rom_addr_o(rom_addr),
        .mem_wr_o(mem_wr), .mem_wr_data_o(wr_data), .acc_o(acc), .zero_o(zero),
        .table_high_byte_reg_o(tbh), .skip_o(skip)
    );

    // Verdict and end of run
    task automatic final_report;
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // One comparison, mismatch reported at once
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // Withdraw the offer, scramble operands, move past the next edge
    task automatic step;
        valid = 1'b0;
        mem_rd = ~mem_rd;
        imm = ~imm;
        @(posedge clk);
        #1;
    endtask : step

    // Offer one operation and hold it up to the edge that takes it;
    // the offer stays up so a following issue changes each signal once
    task automatic issue(input skx_op_t o, input logic [7:0] m, input logic [2:0] b,
                         input logic [7:0] x);
        int n = 0;
        valid = 1'b1;
        op = o;
        mem_rd = m;
        bsel = b;
        imm = x;
        while (ready !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (ready !== 1'b1) begin
            miscompares++;
            final_report();
        end
        @(posedge clk);
        #1;
    endtask : issue

    // Nibble exchange lands in accumulator, memory and flag untouched
    task automatic t_nibble;
        logic [7:0] v [2] = '{8'h3c, 8'h1f};
        issue(OP_XOR_IMM, 8'h00, 3'h0, 8'h00);
        m_acc = 8'h00;
        m_z = 1'b1;
        check(zero, 1'b1);
        for (int i = 0; i < 2; i++) begin
            issue(OP_NIBX_ACC, v[i], 3'h0, 8'h00);
            m_acc = {v[i][3:0], v[i][7:4]};
            check(acc, m_acc);
            check(mem_wr, 1'b0);
            check(zero, m_z);
        end
    endtask : t_nibble

    // Byte, copy and bit skips, taken and not taken
    task automatic t_skips;
        skx_op_t    ops [7] = '{OP_SKZ, OP_SKZ, OP_CPY_SKZ, OP_CPY_SKZ, OP_SKBC,
                                OP_SKBC, OP_SKBC};
        logic [7:0] ms [7] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'hf7, 8'h01, 8'h7f};
        logic [2:0] bs [7] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h0, 3'h7};
        logic       sk [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 7; i++) begin
            issue(ops[i], ms[i], bs[i], 8'h00);
            if (ops[i] == OP_CPY_SKZ) begin
                m_acc = ms[i];
            end
            check(skip, sk[i]);
            check(ready, !sk[i]);
            check(acc, m_acc);
            check(mem_wr, 1'b0);
            check(zero, m_z);
            step();
            check(skip, 1'b0);
            check(ready, 1'b1);
        end
        // Offer during the dummy cycle must be taken only once
        issue(OP_SKZ, 8'h00, 3'h0, 8'h00);
        issue(OP_XOR_IMM, 8'h00, 3'h0, 8'h01);
        m_acc = m_acc ^ 8'h01;
        m_z = (m_acc == 8'h00);
        check(acc, m_acc);
        check(zero, m_z);
        step();
        check(acc, m_acc);
    endtask : t_skips

    // Both table reads: address, low byte to memory, high byte to register
    task automatic t_table;
        logic [13:0] w [2] = '{14'h2b3c, 14'h3f00};
        logic [7:0]  p [2] = '{8'ha5, 8'hff};
        for (int i = 0; i < 2; i++) begin
            tptr = p[i];
            page = 3'h2 - 3'(i);
            issue(i == 0 ? OP_TRD_CUR : OP_TRD_LAST, 8'h00, 3'h0, 8'h00);
            check(rom_rd, 1'b1);
            check(ready, 1'b0);
            if (i == 0) begin
                check(rom_addr, {3'h2, p[i]});
            end else begin
                check(rom_addr, {LAST_PAGE, p[i]});
            end
            tptr = ~p[i];
            page = 3'h5;
            rom = w[i];
            step();
            rom = ~w[i];
            check(mem_wr, 1'b1);
            check(wr_data, w[i][7:0]);
            check(tbh, w[i][13:8]);
            check(acc, m_acc);
            check(zero, m_z);
            step();
            check(mem_wr, 1'b0);
            check(rom_rd, 1'b0);
        end
    endtask : t_table

    // XOR forms back to back, odd steps cancel to zero
    task automatic t_xor;
        skx_op_t    ops [6] = '{OP_XOR_ACC, OP_XOR_ACC, OP_XOR_MEM, OP_XOR_MEM,
                                OP_XOR_IMM, OP_XOR_IMM};
        logic [7:0] v [6] = '{8'h5a, 8'h00, 8'h0f, 8'h00, 8'hff, 8'h00};
        logic [7:0] opd;
        logic [7:0] r;
        for (int i = 0; i < 6; i++) begin
            opd = (i % 2 == 1) ? m_acc : v[i];
            r = m_acc ^ opd;
            issue(ops[i], opd, 3'h0, opd);
            m_z = (r == 8'h00);
            check(zero, m_z);
            if (ops[i] == OP_XOR_MEM) begin
                check(mem_wr, 1'b1);
                check(wr_data, r);
            end else begin
                m_acc = r;
                check(mem_wr, 1'b0);
            end
            check(acc, m_acc);
            check(skip, 1'b0);
        end
    endtask : t_xor

    // Main sequence
    initial begin
        rst = 1'b1;
        valid = 1'b0;
        op = OP_NOP;
        mem_rd = 8'h00;
        bsel = 3'h0;
        imm = 8'h00;
        tptr = 8'h00;
        page = 3'h0;
        rom = 14'h3fff;
        m_acc = ACC_RST;
        m_z = ZERO_RST;
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        step();
        check(acc, ACC_RST);
        check(zero, ZERO_RST);
        check(tbh, THI_RST);
        check(rom_addr, RADR_RST);
        check(skip, 1'b0);
        check(ready, 1'b1);
        check(rom_rd, 1'b0);
        check(mem_wr, 1'b0);
        issue(OP_NOP, 8'h00, 3'h0, 8'h00);
        check(mem_wr, 1'b0);
        check(skip, 1'b0);
        t_nibble();
        t_skips();
        t_table();
        t_xor();
        step();
        final_report();
    end
endmodule : tb_skip_table_xor_instr_exec
`default_nettype wire
